// ==== design/card_clock_divider.sv ====
// Programmable card clock divider with glitch-safe rate and source changes.
`timescale 1ns/1ps
`default_nettype none

module card_clock_divider
    import smartcard_pkg::*;
#(
    parameter int WIDTH = DIV_WIDTH
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic source_ext,
    input wire logic [WIDTH-1:0] divider_value,
    // External clock pin
    input wire logic divider_ext_clock_in,
    // Divided clock
    output logic card_clock
);

    // Refuse counter widths that the compare logic cannot serve.
    if (WIDTH < 2 || WIDTH > 32)
    begin : g_bad_width
        $error("card_clock_divider: WIDTH out of range");
    end

    // ************************************************************
    // External clock resynchronisation
    // ************************************************************
    logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
    logic ext_s1_next, ext_s2_next, ext_s3_next;
    logic ext_rise;

    // two-stage sync
    // Pin is sampled twice before the edge detector sees it.
    always_comb
    begin
        ext_s1_next = divider_ext_clock_in;
        ext_s2_next = ext_s1_reg;
        ext_s3_next = ext_s2_reg;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end
        else
        begin
            ext_s1_reg <= ext_s1_next;
            ext_s2_reg <= ext_s2_next;
            ext_s3_reg <= ext_s3_next;
        end
    end

    assign ext_rise = ext_s2_reg & ~ext_s3_reg;

    // ************************************************************
    // Divider counter
    // ************************************************************
    logic [WIDTH-1:0] cnt_reg, cnt_next, val_reg, val_next;
    logic src_reg, src_next, out_reg, out_next;
    logic tick;

    // selected source
    // Processor clock counts every cycle, external clock on its rising edge.
    assign tick = src_reg ? ext_rise : 1'b1;

    // half period count
    // Each phase lasts the programmed number of source ticks, so the
    // output period is twice the value.
    always_comb
    begin
        cnt_next = cnt_reg;
        val_next = val_reg;
        src_next = src_reg;
        out_next = out_reg;
        if (!enable)
        begin
            cnt_next = '0;
            out_next = CARD_CLOCK_RESET;
            val_next = divider_value;
            src_next = source_ext;
        end
        else if (val_reg == '0)
        begin
            val_next = divider_value;
            src_next = source_ext;
        end
        else if (tick)
        begin
            if (cnt_reg + 1'b1 >= val_reg)
            begin
                out_next = ~out_reg;
                cnt_next = '0;
                val_next = divider_value;
                src_next = source_ext;
            end
            else
                cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg <= '0;
            val_reg <= '0;
            src_reg <= 1'b0;
            out_reg <= CARD_CLOCK_RESET;
        end
        else
        begin
            cnt_reg <= cnt_next;
            val_reg <= val_next;
            src_reg <= src_next;
            out_reg <= out_next;
        end
    end

    assign card_clock = out_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    // disabled reset
    div_hold_a: assert property (@(posedge clk) disable iff (rst) !enable |=> (!out_reg && cnt_reg == '0))
        else $error("Divider not held while disabled");

    val_stable_a: assert property (@(posedge clk) disable iff (rst) (enable && $past(enable) && $changed(val_reg) && $past(val_reg) != '0) |-> $changed(out_reg))
        else $error("Divider value changed away from an output edge");

    cnt_bound_a: assert property (@(posedge clk) disable iff (rst) (enable && val_reg != '0) |-> cnt_reg < val_reg)
        else $error("Divider count passed programmed value");

    src_switch_a: assert property (@(posedge clk) disable iff (rst) (enable && $past(enable) && $changed(src_reg) && $past(val_reg) != '0) |-> $changed(out_reg))
        else $error("Source switched in mid phase");

endmodule : card_clock_divider

`default_nettype wire

// ==== design/smartcard_clock_and_link.sv ====
// Two card ports: clock divider, pin drivers and smartcard-mode link helpers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - A 16-bit counter divides the processor clock or an external clock pin.
// - Card clock frequency is the source frequency over twice the divider value.
// - A new divider value is taken at a card clock edge, or at once while disabled or while the held value is zero.
// - No phase during a rate change is shorter than the old or new phase.
// - Control selects the divider source and enables the card clock.
// - With enable low, divider and clock output stay in reset.
// - Pin function routes serial transmit to card data and divider to card clock.
// - Card data is open drain; card clock too for 5V cards.
// - Each bit on the data line lasts one card-clock based time unit.
// - Port zero serves serial channel zero, port one serial channel two.
// - Parity error with half stop bit pulls transmit low one baud period.
// - After shift empty, transmitter empty stays low until the guard count.
// - Receiver enable clears after each received character in smartcard mode.
module smartcard_clock_and_link
    import smartcard_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Software control and serial channel signals, index 0 and 1
    input wire card_ctl_t ctl [PORTS],
    input wire chan_in_t chan [PORTS],
    input wire gp_out_t gp_out [PORTS],
    // Card pins, open drain style
    input wire logic divider_ext_clock_in [PORTS],
    input wire logic card_data_in [PORTS],
    input wire logic card_present_in [PORTS],
    output logic card_clock_out [PORTS],
    output logic card_clock_oe [PORTS],
    output logic card_data_out [PORTS],
    output logic card_data_oe [PORTS],
    output logic card_reset_out [PORTS],
    output logic supply_enable_out [PORTS],
    output logic prog_voltage_enable_out [PORTS],
    // Back to serial channel and software
    output logic rx_data [PORTS],
    output logic transmitter_empty_flag [PORTS],
    output logic rx_enable [PORTS],
    output logic card_present [PORTS]
);

    // Refuse port counts that the pin arrays cannot serve.
    if (PORTS < 1 || PORTS > 8)
    begin : g_bad_ports
        $error("smartcard_clock_and_link: PORTS out of range");
    end

    // port to channel map
    // Index 0 is wired to serial channel zero, index 1 to serial channel two.
    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
        // ************************************************************
        // Card clock divider
        // ************************************************************
        logic div_clock;

        card_clock_divider #(
            .WIDTH(DIV_WIDTH)
        ) u_div (
            .clk(clk),
            .rst(rst),
            .enable(ctl[p].clock_enable),
            .source_ext(ctl[p].source_ext),
            .divider_value(ctl[p].divider_value),
            .divider_ext_clock_in(divider_ext_clock_in[p]),
            .card_clock(div_clock)
        );

        // ************************************************************
        // Input synchronisers
        // ************************************************************
        logic [SYNC_STAGES-1:0] data_sync_reg, data_sync_next;
        logic [SYNC_STAGES-1:0] det_sync_reg, det_sync_next;

        // Data and detect pins pass two flops before use.
        always_comb
        begin
            data_sync_next = {data_sync_reg[0], card_data_in[p]};
            det_sync_next = {det_sync_reg[0], card_present_in[p]};
        end

        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                data_sync_reg <= {SYNC_STAGES{DATA_IDLE}};
                det_sync_reg <= '0;
            end
            else
            begin
                data_sync_reg <= data_sync_next;
                det_sync_reg <= det_sync_next;
            end
        end

        // ************************************************************
        // Smartcard-mode link helpers
        // ************************************************************
        logic nack_reg, nack_next;
        logic [GUARD_WIDTH-1:0] guard_reg, guard_next;
        logic rxen_reg, rxen_next;
        logic txe_reg, txe_next;

        // Nack, guard counter and receiver enable next state.
        always_comb
        begin
            nack_next = nack_reg;
            guard_next = guard_reg;
            rxen_next = rxen_reg;
            // parity nack
            // Held from frame end until the next baud tick, one baud period.
            if (nack_reg && chan[p].baud_tick)
                nack_next = 1'b0;
            if (ctl[p].smartcard_mode && ctl[p].half_stop && chan[p].parity_error)
                nack_next = 1'b1;
            if (!chan[p].shift_empty)
                guard_next = GUARD_RESET;
            else if (chan[p].baud_tick && guard_reg != ctl[p].guard_time)
                guard_next = guard_reg + 1'b1;
            if (ctl[p].smartcard_mode)
                txe_next = chan[p].shift_empty && (guard_reg == ctl[p].guard_time);
            else
                txe_next = chan[p].shift_empty;
            // receiver auto disable
            // Software write takes priority over the hardware clear.
            if (chan[p].rx_enable_set)
                rxen_next = 1'b1;
            else if (chan[p].rx_enable_clear || (ctl[p].smartcard_mode && chan[p].char_done))
                rxen_next = 1'b0;
        end

        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                nack_reg <= 1'b0;
                guard_reg <= GUARD_RESET;
                rxen_reg <= 1'b0;
                txe_reg <= 1'b0;
            end
            else
            begin
                nack_reg <= nack_next;
                guard_reg <= guard_next;
                rxen_reg <= rxen_next;
                txe_reg <= txe_next;
            end
        end

        // ************************************************************
        // Pin drivers
        // ************************************************************
        logic clk_o_reg, clk_o_next, clk_oe_reg, clk_oe_next;
        logic dat_oe_reg, dat_oe_next;
        gp_out_t gp_reg, gp_next;

        // Drive levels and enables for the card pins.
        always_comb
        begin
            clk_o_next = div_clock;
            // open drain drive
            // A 5V card sees only a pulled-low clock; data is always open drain.
            clk_oe_next = ctl[p].five_volt_card ? ~div_clock : 1'b1;
            // one bit per unit
            // Transmit bits pass straight through, so their length is the channel's.
            dat_oe_next = ~chan[p].tx_data | nack_reg;
            gp_next = gp_out[p];
        end

        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                clk_o_reg <= CARD_CLOCK_RESET;
                clk_oe_reg <= 1'b0;
                dat_oe_reg <= 1'b0;
                gp_reg <= '0;
            end
            else
            begin
                clk_o_reg <= clk_o_next;
                clk_oe_reg <= clk_oe_next;
                dat_oe_reg <= dat_oe_next;
                gp_reg <= gp_next;
            end
        end

        assign card_clock_out[p] = clk_o_reg;
        assign card_clock_oe[p] = clk_oe_reg;
        assign card_data_out[p] = 1'b0;
        assign card_data_oe[p] = dat_oe_reg;
        assign card_reset_out[p] = gp_reg.card_reset;
        assign supply_enable_out[p] = gp_reg.supply_enable;
        assign prog_voltage_enable_out[p] = gp_reg.prog_voltage_enable;
        assign rx_data[p] = data_sync_reg[SYNC_STAGES-1];
        assign transmitter_empty_flag[p] = txe_reg;
        assign rx_enable[p] = rxen_reg;
        assign card_present[p] = det_sync_reg[SYNC_STAGES-1];

        // ************************************************************
        // Checks
        // ************************************************************
        // parity nack
        nack_start_a: assert property (@(posedge clk) disable iff (rst) (ctl[p].smartcard_mode && ctl[p].half_stop && chan[p].parity_error) |-> ##2 card_data_oe[p])
            else $error("Parity nack did not pull data low");

        nack_end_a: assert property (@(posedge clk) disable iff (rst) (nack_reg && chan[p].baud_tick && !chan[p].parity_error) |=> !nack_reg)
            else $error("Parity nack longer than one baud period");

        guard_hold_a: assert property (@(posedge clk) disable iff (rst) (ctl[p].smartcard_mode && guard_reg != ctl[p].guard_time && $stable(ctl[p].guard_time)) |=> !txe_reg)
            else $error("Transmitter empty raised before guard time");

        rxen_clear_a: assert property (@(posedge clk) disable iff (rst) (ctl[p].smartcard_mode && chan[p].char_done && !chan[p].rx_enable_set) |=> !rx_enable[p])
            else $error("Receiver enable not cleared after a character");

        clk_drain_a: assert property (@(posedge clk) disable iff (rst) (card_clock_oe[p] && $past(ctl[p].five_volt_card)) |-> !card_clock_out[p])
            else $error("5V card clock driven high");

        data_route_a: assert property (@(posedge clk) disable iff (rst) (!chan[p].tx_data) |=> card_data_oe[p])
            else $error("Transmit low not routed to card data");
    end

endmodule : smartcard_clock_and_link

`default_nettype wire

// ==== design/smartcard_pkg.sv ====
// Shared constants and carrier types for the smartcard clock and link block.
package smartcard_pkg;

    // ************************************************************
    // Sizes and reset values
    // ************************************************************
    localparam int NUM_PORTS = 2;
    localparam int DIV_WIDTH = 16;
    localparam int GUARD_WIDTH = 8;
    localparam int SYNC_STAGES = 2;
    localparam logic [DIV_WIDTH-1:0] DIV_VALUE_RESET = 16'h0000;
    localparam logic [GUARD_WIDTH-1:0] GUARD_RESET = 8'h00;
    localparam logic CARD_CLOCK_RESET = 1'b0;
    localparam logic DATA_IDLE = 1'b1;

    // ************************************************************
    // Carrier types
    // ************************************************************
    // Per-port configuration from software.
    typedef struct packed {
        logic clock_enable;
        logic source_ext;
        logic five_volt_card;
        logic smartcard_mode;
        logic half_stop;
        logic [GUARD_WIDTH-1:0] guard_time;
        logic [DIV_WIDTH-1:0] divider_value;
    } card_ctl_t;

    // Per-port signals from the async serial channel core.
    typedef struct packed {
        logic tx_data;
        logic parity_error;
        logic shift_empty;
        logic char_done;
        logic baud_tick;
        logic rx_enable_set;
        logic rx_enable_clear;
    } chan_in_t;

    // Per-port general purpose pin levels driven by software.
    typedef struct packed {
        logic card_reset;
        logic supply_enable;
        logic prog_voltage_enable;
    } gp_out_t;

endpackage : smartcard_pkg

// ==== testbench/card_model.sv ====
// Behavioural smartcard at the far side of one card port.
`timescale 1ns/1ps
`default_nettype none

module card_model
(
    // Clock
    input wire logic clk,
    // Pins from the port
    input wire logic clock_pin,
    input wire logic clock_oe,
    input wire logic five_volt,
    input wire logic data_oe,
    // Card behaviour chosen by the bench
    input wire logic drive_low,
    input wire logic clear_stats,
    // Line level and measured clock phases
    output logic data_line,
    output int last_phase,
    output int min_phase
);
    logic clock_wire;
    logic prev_wire = 1'b0;
    logic seen_edge = 1'b0;
    int run_len = 1;

    // shared data line
    // The data line is pulled up unless the port or the card pulls it low.
    assign data_line = !(data_oe || drive_low);
    // A 5V clock pin is released high by the pull-up when not driven low.
    assign clock_wire = five_volt ? !clock_oe : clock_pin;

    // clock phase meter
    // Measures each whole clock phase in processor cycles; the partial phase after a clear is skipped.
    always @(posedge clk)
    begin
        if (clear_stats)
        begin
            run_len <= 1;
            min_phase <= 1000;
            seen_edge <= 1'b0;
            prev_wire <= clock_wire;
        end
        else if (clock_wire !== prev_wire)
        begin
            if (seen_edge)
            begin
                last_phase <= run_len;
                if (run_len < min_phase)
                    min_phase <= run_len;
            end
            seen_edge <= 1'b1;
            run_len <= 1;
            prev_wire <= clock_wire;
        end
        else
            run_len <= run_len + 1;
    end
endmodule : card_model

`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking testbench for the two-port smartcard clock and link block.
`timescale 1ns/1ps
`default_nettype none

module tb
    import smartcard_pkg::*;
;
    logic clk;
    logic rst;
    card_ctl_t ctl [2];
    chan_in_t chan [2];
    gp_out_t gp_out [2];
    logic divider_ext_clock_in [2];
    logic card_data_in [2];
    logic card_present_in [2];
    logic card_clock_out [2];
    logic card_clock_oe [2];
    logic card_data_out [2];
    logic card_data_oe [2];
    logic card_reset_out [2];
    logic supply_enable_out [2];
    logic prog_voltage_enable_out [2];
    logic rx_data [2];
    logic transmitter_empty_flag [2];
    logic rx_enable [2];
    logic card_present [2];
    logic [1:0] drive_low;
    logic [1:0] clear_stats;
    int last_phase [2];
    int min_phase [2];
    logic ext_run;
    logic [1:0] ext_div;
    int n_errors;
    int total_checks;
    logic [7:0] tx_byte;

    smartcard_clock_and_link dut_u (.clk(clk), .rst(rst), .ctl(ctl), .chan(chan), .gp_out(gp_out),
        .divider_ext_clock_in(divider_ext_clock_in), .card_data_in(card_data_in),
        .card_present_in(card_present_in), .card_clock_out(card_clock_out), .card_clock_oe(card_clock_oe),
        .card_data_out(card_data_out), .card_data_oe(card_data_oe), .card_reset_out(card_reset_out),
        .supply_enable_out(supply_enable_out), .prog_voltage_enable_out(prog_voltage_enable_out),
        .rx_data(rx_data), .transmitter_empty_flag(transmitter_empty_flag), .rx_enable(rx_enable),
        .card_present(card_present));

    card_model m0 (.clk(clk), .clock_pin(card_clock_out[0]), .clock_oe(card_clock_oe[0]),
        .five_volt(ctl[0].five_volt_card), .data_oe(card_data_oe[0]), .drive_low(drive_low[0]),
        .clear_stats(clear_stats[0]), .data_line(card_data_in[0]), .last_phase(last_phase[0]),
        .min_phase(min_phase[0]));
    card_model m1 (.clk(clk), .clock_pin(card_clock_out[1]), .clock_oe(card_clock_oe[1]),
        .five_volt(ctl[1].five_volt_card), .data_oe(card_data_oe[1]), .drive_low(drive_low[1]),
        .clear_stats(clear_stats[1]), .data_line(card_data_in[1]), .last_phase(last_phase[1]),
        .min_phase(min_phase[1]));

    // Processor clock of 50 ns.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // External divider clock with a rising edge every fourth processor cycle.
    always @(posedge clk)
    begin
        #1;
        if (ext_run)
            ext_div = ext_div + 2'h1;
        divider_ext_clock_in[1] = ext_div[1];
    end

    // Moves to just after the n-th next rising edge.
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Compares one value and counts it.
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Sends one baud tick pulse on a port.
    task baud_pulse(input int p);
        chan[p].baud_tick = 1'b1;
        tick(1);
        chan[p].baud_tick = 1'b0;
    endtask : baud_pulse

    // Restarts the phase meter of a port.
    task restart_meter(input int p);
        clear_stats[p] = 1'b1;
        tick(1);
        clear_stats[p] = 1'b0;
    endtask : restart_meter

    // Prints the counts and the verdict, then ends the run.
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // Watchdog against a hang.
    initial
    begin
        #(3000 * 50);
        n_errors++;
        give_verdict;
    end

    // Main test sequence.
    initial
    begin
        n_errors = 0;
        total_checks = 0;
        rst = 1'b1;
        ext_run = 1'b0;
        ext_div = 2'h0;
        drive_low = 2'h0;
        tx_byte = 8'hA6;
        clear_stats = 2'h0;
        for (int p = 0; p < 2; p++)
        begin
            ctl[p] = '0;
            chan[p] = '0;
            chan[p].tx_data = 1'b1;
            gp_out[p] = '0;
            divider_ext_clock_in[p] = 1'b0;
            card_present_in[p] = 1'b0;
        end
        tick(4);
        rst = 1'b0;
        tick(1);
        check("clock after reset", card_clock_out[0], 0);
        check("data oe after reset", card_data_oe[0], 0);
        ctl[0].divider_value = 16'h0002;
        ctl[0].clock_enable = 1'b1;
        tick(12);
        check("phase of two", last_phase[0], 2);
        restart_meter(0);
        ctl[0].divider_value = 16'h0005;
        tick(40);
        check("phase of five", last_phase[0], 5);
        check("no short phase", min_phase[0] >= 2, 1);
        ctl[0].clock_enable = 1'b0;
        tick(3);
        check("clock held off", card_clock_out[0], 0);
        ctl[0].five_volt_card = 1'b1;
        ctl[0].divider_value = 16'h0003;
        ctl[0].clock_enable = 1'b1;
        tick(20);
        check("open drain phase", last_phase[0], 3);
        repeat (12)
        begin
            check("oe while high", card_clock_out[0] & card_clock_oe[0], 0);
            tick(1);
        end
        ctl[0].clock_enable = 1'b0;
        ctl[1].source_ext = 1'b1;
        ctl[1].divider_value = 16'h0002;
        ctl[1].clock_enable = 1'b1;
        ext_run = 1'b1;
        tick(60);
        check("external phase", last_phase[1], 8);
        restart_meter(1);
        ctl[1].source_ext = 1'b0;
        tick(30);
        check("source switch", last_phase[1], 2);
        check("switch no short", min_phase[1] >= 2, 1);
        // channel setup
        // The serial channel runs in smartcard mode with a half stop bit.
        ctl[0].smartcard_mode = 1'b1;
        ctl[0].half_stop = 1'b1;
        chan[0].parity_error = 1'b1;
        tick(1);
        chan[0].parity_error = 1'b0;
        tick(1);
        check("nack start", card_data_oe[0], 1);
        check("nack on line", card_data_in[0], 0);
        check("data pin low", card_data_out[0], 0);
        tick(4);
        baud_pulse(0);
        check("nack held", card_data_oe[0], 1);
        tick(1);
        check("nack end", card_data_oe[0], 0);
        ctl[0].half_stop = 1'b0;
        chan[0].parity_error = 1'b1;
        tick(1);
        chan[0].parity_error = 1'b0;
        tick(3);
        check("no nack full stop", card_data_oe[0], 0);
        ctl[0].guard_time = 8'h03;
        chan[0].shift_empty = 1'b1;
        tick(2);
        check("guard start", transmitter_empty_flag[0], 0);
        baud_pulse(0);
        tick(1);
        baud_pulse(0);
        tick(1);
        check("guard two ticks", transmitter_empty_flag[0], 0);
        baud_pulse(0);
        tick(1);
        check("guard reached", transmitter_empty_flag[0], 1);
        chan[0].shift_empty = 1'b0;
        tick(2);
        check("empty falls", transmitter_empty_flag[0], 0);
        ctl[0].smartcard_mode = 1'b0;
        chan[0].shift_empty = 1'b1;
        tick(2);
        check("plain empty", transmitter_empty_flag[0], 1);
        ctl[1].smartcard_mode = 1'b1;
        chan[1].rx_enable_set = 1'b1;
        tick(1);
        chan[1].rx_enable_set = 1'b0;
        check("rx enable set", rx_enable[1], 1);
        chan[1].char_done = 1'b1;
        tick(1);
        check("rx enable cleared", rx_enable[1], 0);
        chan[1].rx_enable_set = 1'b1;
        tick(1);
        chan[1].rx_enable_set = 1'b0;
        check("set wins", rx_enable[1], 1);
        ctl[1].smartcard_mode = 1'b0;
        tick(1);
        chan[1].char_done = 1'b0;
        check("plain mode keeps", rx_enable[1], 1);
        // inverse convention
        // Software sends the inverted byte MSB first; each bit stands four cycles on the line.
        for (int i = 7; i >= 0; i--)
        begin
            chan[0].tx_data = !tx_byte[i];
            tick(2);
            check("line bit", card_data_in[0], !tx_byte[i]);
            tick(2);
            check("rx data bit", rx_data[0], !tx_byte[i]);
        end
        chan[0].tx_data = 1'b1;
        gp_out[0].supply_enable = 1'b1;
        gp_out[1].card_reset = 1'b1;
        gp_out[1].prog_voltage_enable = 1'b1;
        card_present_in[1] = 1'b1;
        drive_low[1] = 1'b1;
        tick(4);
        check("card reset pin", card_reset_out[1], 1);
        check("supply pin", supply_enable_out[1], 0);
        check("supply pin port zero", supply_enable_out[0], 1);
        check("prog voltage pin", prog_voltage_enable_out[1], 1);
        check("detect", card_present[1], 1);
        check("rx data port one", rx_data[1], 0);
        check("rx data port zero", rx_data[0], 1);
        check("detect port zero", card_present[0], 0);
        rst = 1'b1;
        tick(1);
        check("clock in mid reset", card_clock_out[1], 0);
        check("reset pin in reset", card_reset_out[1], 0);
        give_verdict;
    end
endmodule : tb

`default_nettype wire
